// ---- hw/cicr_pkg.sv ----
// Constants for the charger input configuration register bank
package cicr_pkg;

    // Serial target address, seven bits
    localparam logic [6:0] TARGET_ADDR = 7'h6b;

    // Register offsets and the read answer beyond the mapped range
    localparam logic [7:0] OFFSET_INPUT_SOURCE = 8'h00;
    localparam logic [7:0] OFFSET_BOOST_TEMP = 8'h01;
    localparam logic [7:0] OFFSET_CONVERSION = 8'h02;
    localparam logic [7:0] OFFSET_LAST_MAPPED = 8'h14;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'hff;
    localparam logic [7:0] OUTSIDE_BLOCK_READ_VALUE = 8'h00;

    // Reset values
    localparam logic [7:0] RESET_INPUT_SOURCE = 8'h08;
    localparam logic [7:0] RESET_BOOST_TEMP = 8'h06;
    localparam logic [7:0] RESET_CONVERSION = 8'h11;

    // Bits restored by a watchdog expiry; the rest only by register reset or power reset
    localparam logic [7:0] WATCHDOG_MASK_INPUT_SOURCE = 8'hc0;
    localparam logic [7:0] WATCHDOG_MASK_BOOST_TEMP = 8'he0;
    localparam logic [7:0] WATCHDOG_MASK_CONVERSION = 8'he2;

    // Field positions
    localparam int HIZ_BIT = 7;
    localparam int LIMIT_PIN_ENABLE_BIT = 6;
    localparam int CODE_MSB = 5;
    localparam int HOT_MSB = 7;
    localparam int HOT_LSB = 6;
    localparam int COLD_BIT = 5;
    localparam int OFFSET_MSB = 4;
    localparam logic [1:0] HOT_PROTECT_OFF = 2'h3;

    // Current limit arithmetic, milliamps
    localparam logic [11:0] CURRENT_LIMIT_PIN_OFFSET_MA = 12'h064;
    localparam logic [11:0] CURRENT_LIMIT_PIN_STEP_MA = 12'h032;
    localparam logic [11:0] CURRENT_LIMIT_PIN_USB_MA = 12'h1f4;
    localparam logic [11:0] CURRENT_LIMIT_PIN_HIGH_MA = 12'hcb2;
    localparam logic [5:0] CODE_USB = 6'((CURRENT_LIMIT_PIN_USB_MA - CURRENT_LIMIT_PIN_OFFSET_MA) / CURRENT_LIMIT_PIN_STEP_MA);
    localparam logic [5:0] CODE_HIGH = 6'((CURRENT_LIMIT_PIN_HIGH_MA - CURRENT_LIMIT_PIN_OFFSET_MA) / CURRENT_LIMIT_PIN_STEP_MA);

    // Voltage limit arithmetic, millivolts
    localparam logic [15:0] VOFF_STEP_MV = 16'h0064;
    localparam logic [15:0] VLIMIT_MIN_MV = 16'h0f3c;
    localparam logic [15:0] VLIMIT_MAX_MV = 16'h3bc4;
    localparam logic [15:0] VBUS_DOUBLE_MV = 16'h1770;

endpackage : cicr_pkg

// ---- hw/cicr_reg_if.sv ----
// Write port and register contents between serial engine and register file
`timescale 1ns/1ps
interface cicr_reg_if;
    logic write_strobe;
    logic [7:0] write_addr;
    logic [7:0] write_data;
    logic source_select;
    logic [7:0] input_source_control;
    logic [7:0] boost_temp_and_voltage_offset;
    logic [7:0] conversion_and_detection_control;

    modport engine (
        output write_strobe,
        output write_addr,
        output write_data,
        output source_select,
        input input_source_control,
        input boost_temp_and_voltage_offset,
        input conversion_and_detection_control
    );

    modport regs (
        input write_strobe,
        input write_addr,
        input write_data,
        input source_select,
        output input_source_control,
        output boost_temp_and_voltage_offset,
        output conversion_and_detection_control
    );
endinterface : cicr_reg_if

// ---- hw/cicr_regfile.sv ----
// Three configuration registers with their reset sources
`timescale 1ns/1ps
module cicr_regfile (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic register_reset,
    input wire logic watchdog_expired,
    input wire logic detection_done,
    cicr_reg_if.regs bus
);

    logic [7:0] next_input_source_control;
    logic [7:0] next_boost_temp_and_voltage_offset;
    logic [7:0] next_conversion_and_detection_control;
    logic [5:0] detected_code;

    ////////////////////////////////////////////////////////////////////////
    // Next values: host write, then watchdog, then detection override
    // code per source select
    assign detected_code = bus.source_select ? cicr_pkg::CODE_USB : cicr_pkg::CODE_HIGH;

    always_comb
    begin
        next_input_source_control = bus.input_source_control;
        next_boost_temp_and_voltage_offset = bus.boost_temp_and_voltage_offset;
        next_conversion_and_detection_control = bus.conversion_and_detection_control;
        if (bus.write_strobe && bus.write_addr == cicr_pkg::OFFSET_INPUT_SOURCE)
        begin
            next_input_source_control = bus.write_data;
        end
        else if (bus.write_strobe && bus.write_addr == cicr_pkg::OFFSET_BOOST_TEMP)
        begin
            next_boost_temp_and_voltage_offset = bus.write_data;
        end
        else if (bus.write_strobe && bus.write_addr == cicr_pkg::OFFSET_CONVERSION)
        begin
            next_conversion_and_detection_control = bus.write_data;
        end
        if (watchdog_expired)
        begin
            next_input_source_control = (next_input_source_control & ~cicr_pkg::WATCHDOG_MASK_INPUT_SOURCE)
                | (cicr_pkg::RESET_INPUT_SOURCE & cicr_pkg::WATCHDOG_MASK_INPUT_SOURCE);
            next_boost_temp_and_voltage_offset = (next_boost_temp_and_voltage_offset & ~cicr_pkg::WATCHDOG_MASK_BOOST_TEMP)
                | (cicr_pkg::RESET_BOOST_TEMP & cicr_pkg::WATCHDOG_MASK_BOOST_TEMP);
            next_conversion_and_detection_control = (next_conversion_and_detection_control & ~cicr_pkg::WATCHDOG_MASK_CONVERSION)
                | (cicr_pkg::RESET_CONVERSION & cicr_pkg::WATCHDOG_MASK_CONVERSION);
        end
        // hardware load beats a host write
        if (detection_done)
        begin
            next_input_source_control[cicr_pkg::CODE_MSB:0] = detected_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage; register reset and power reset restore everything
    // documented reset values
    always_ff @(posedge clock)
    begin
        if (!rst_b || register_reset)
        begin
            bus.input_source_control <= cicr_pkg::RESET_INPUT_SOURCE;
            bus.boost_temp_and_voltage_offset <= cicr_pkg::RESET_BOOST_TEMP;
            bus.conversion_and_detection_control <= cicr_pkg::RESET_CONVERSION;
        end
        else
        begin
            bus.input_source_control <= next_input_source_control;
            bus.boost_temp_and_voltage_offset <= next_boost_temp_and_voltage_offset;
            bus.conversion_and_detection_control <= next_conversion_and_detection_control;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_reset_values: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rst_b) |-> bus.input_source_control == cicr_pkg::RESET_INPUT_SOURCE
            && bus.boost_temp_and_voltage_offset == cicr_pkg::RESET_BOOST_TEMP
            && bus.conversion_and_detection_control == cicr_pkg::RESET_CONVERSION)
        else $error("registers not at reset values after reset");

    a_watchdog_keeps_codes: assert property (@(posedge clock) disable iff (!rst_b)
        watchdog_expired && !register_reset && !bus.write_strobe && !detection_done
        |=> bus.boost_temp_and_voltage_offset[7:5] == 3'h0
            && bus.input_source_control[7:6] == 2'h0
            && $stable(bus.input_source_control[cicr_pkg::CODE_MSB:0])
            && $stable(bus.boost_temp_and_voltage_offset[cicr_pkg::OFFSET_MSB:0]))
        else $error("watchdog restore wrong");

    a_detect_load_code: assert property (@(posedge clock) disable iff (!rst_b)
        detection_done && !register_reset
        |=> bus.input_source_control[cicr_pkg::CODE_MSB:0]
            == ($past(bus.source_select) ? 6'h08 : 6'h3f))
        else $error("detection did not load the limit code");

    c_detection: cover property (@(posedge clock) disable iff (!rst_b)
        detection_done && bus.source_select);

endmodule : cicr_regfile

// ---- hw/cicr_top.sv ----
// Serial target engine and derived limits for the input configuration bank
//
// Function
// - Answer serial address 6BH plus direction bit
// - Register 0 bit 6 enables limit pin
// - Bits 5:0 code: 100mA plus 50mA steps
// - Effective limit is smaller of register, pin
// - Detection completion overwrites current limit code
// - Select high loads 500mA, low 3.25A
// - Hot threshold select in register 1 bits 7:6
// - Hot select 11 disables boost thermal protection
// - Register 1 bit 5 selects cold threshold
// - Bits 4:0 voltage offset, 100mV per count
// - Clamp voltage threshold between 3.9V and 15.3V
// - Offset doubled when unloaded input above 6V
// - All bits read/write, reset to defaults
// - Reads above 0x14 return 0xFF
`timescale 1ns/1ps
module cicr_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b,
    input wire logic register_reset,
    input wire logic watchdog_expired,
    input wire logic detection_done,
    input wire logic source_select_pin,
    input wire logic [11:0] current_limit_pin_ma,
    input wire logic [15:0] vbus_noload_mv,
    output logic input_high_impedance_enable,
    output logic [11:0] effective_input_current_limit_ma,
    output logic [1:0] boost_hot_threshold_select,
    output logic boost_thermal_protect_enable,
    output logic boost_cold_threshold_select,
    output logic [15:0] input_voltage_limit_threshold_mv,
    output logic [7:0] conversion_control
);

    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_ADDR = 9'h002,
        S_ADDR_ACK = 9'h004,
        S_REG = 9'h008,
        S_REG_ACK = 9'h010,
        S_WDATA = 9'h020,
        S_WDATA_ACK = 9'h040,
        S_RDATA = 9'h080,
        S_RDATA_ACK = 9'h100
    } cicr_state_type;

    cicr_reg_if bus ();
    cicr_state_type state;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic scl_d;
    logic sda_d;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    logic receiving;
    logic [3:0] bit_count;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] reg_ptr;
    logic read_dir;
    logic host_ack;
    logic [11:0] reg_limit_ma;
    logic [15:0] offset_mv;
    logic [15:0] scaled_offset_mv;
    logic [5:0] limit_code;
    logic [4:0] voltage_offset;

    cicr_regfile regfile (
        .clock(clock),
        .rst_b(rst_b),
        .register_reset(register_reset),
        .watchdog_expired(watchdog_expired),
        .detection_done(detection_done),
        .bus(bus.regs)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two flops on each pin: scl, sda, source select
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sync_a <= 3'h7;
            sync_b <= 3'h7;
        end
        else
        begin
            sync_a <= {source_select_pin, sda_in, scl_in};
            sync_b <= sync_a;
        end
    end

    // Delayed copies for edge detection, taken from the second flop
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= sync_b[0];
            sda_d <= sync_b[1];
        end
    end

    assign bus.source_select = sync_b[2];
    assign start_seen = scl_d && sync_b[0] && sda_d && !sync_b[1];
    assign stop_seen = scl_d && sync_b[0] && !sda_d && sync_b[1];
    assign scl_rise = !scl_d && sync_b[0];
    assign scl_fall = scl_d && !sync_b[0];
    assign receiving = state == S_ADDR || state == S_REG || state == S_WDATA;

    // mapped, outside this bank, or unmapped
    function automatic logic [7:0] read_value(input logic [7:0] addr);
        if (addr == cicr_pkg::OFFSET_INPUT_SOURCE)
            read_value = bus.input_source_control;
        else if (addr == cicr_pkg::OFFSET_BOOST_TEMP)
            read_value = bus.boost_temp_and_voltage_offset;
        else if (addr == cicr_pkg::OFFSET_CONVERSION)
            read_value = bus.conversion_and_detection_control;
        else if (addr <= cicr_pkg::OFFSET_LAST_MAPPED)
            read_value = cicr_pkg::OUTSIDE_BLOCK_READ_VALUE;
        else
            read_value = cicr_pkg::UNMAPPED_READ_VALUE;
    endfunction : read_value

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer; start and stop win over clock edges
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            state <= S_IDLE;
        else if (start_seen)
            state <= S_ADDR;
        else if (stop_seen)
            state <= S_IDLE;
        else if (scl_fall)
        begin
            case (state)
                S_ADDR: if (bit_count == 4'h8)
                    state <= (shift[7:1] == cicr_pkg::TARGET_ADDR) ? S_ADDR_ACK : S_IDLE;
                S_ADDR_ACK: state <= read_dir ? S_RDATA : S_REG;
                S_REG: if (bit_count == 4'h8) state <= S_REG_ACK;
                S_REG_ACK: state <= S_WDATA;
                S_WDATA: if (bit_count == 4'h8) state <= S_WDATA_ACK;
                S_WDATA_ACK: state <= S_WDATA;
                S_RDATA: if (bit_count == 4'h8) state <= S_RDATA_ACK;
                S_RDATA_ACK: state <= host_ack ? S_RDATA : S_IDLE;
                default: state <= state;
            endcase
        end
    end

    // Bit counter, counted on rising clock, cleared after eight
    always_ff @(posedge clock)
    begin
        if (!rst_b || start_seen)
            bit_count <= 4'h0;
        else if (scl_rise && (receiving || state == S_RDATA))
            bit_count <= bit_count + 4'h1;
        else if (scl_fall && bit_count == 4'h8)
            bit_count <= 4'h0;
    end

    // Receive shifter, msb first
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            shift <= 8'h00;
        else if (scl_rise && receiving)
            shift <= {shift[6:0], sync_b[1]};
    end

    // Direction bit and host acknowledge of read bytes
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            read_dir <= 1'b0;
            host_ack <= 1'b0;
        end
        else
        begin
            if (scl_fall && state == S_ADDR && bit_count == 4'h8)
                read_dir <= shift[0];
            if (scl_rise && state == S_RDATA_ACK)
                host_ack <= !sync_b[1];
        end
    end

    // Register pointer; auto-increments after every acknowledged data byte
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            reg_ptr <= 8'h00;
        else if (scl_fall && state == S_REG && bit_count == 4'h8)
            reg_ptr <= shift;
        else if (scl_fall && (state == S_WDATA_ACK || (state == S_RDATA_ACK && host_ack)))
            reg_ptr <= reg_ptr + 8'h01;
    end

    // Transmit byte, loaded when a read byte begins
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            tx <= 8'h00;
        else if (scl_fall && state == S_ADDR_ACK && read_dir)
            tx <= read_value(reg_ptr);
        else if (scl_fall && state == S_RDATA_ACK && host_ack)
            tx <= read_value(reg_ptr + 8'h01);
        else if (scl_fall && state == S_RDATA && bit_count != 4'h8)
            tx <= {tx[6:0], 1'b1};
    end

    // One-cycle write strobe at the end of each data byte
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            bus.write_strobe <= 1'b0;
            bus.write_addr <= 8'h00;
            bus.write_data <= 8'h00;
        end
        else
        begin
            bus.write_strobe <= scl_fall && state == S_WDATA && bit_count == 4'h8;
            if (scl_fall && state == S_WDATA && bit_count == 4'h8)
            begin
                bus.write_addr <= reg_ptr;
                bus.write_data <= shift;
            end
        end
    end

    // Open-drain data pin; enable low pulls the line down
    assign sda_out = 1'b0;
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            sda_oe_b <= 1'b1;
        else
            sda_oe_b <= !(state == S_ADDR_ACK || state == S_REG_ACK || state == S_WDATA_ACK
                || (state == S_RDATA && !tx[7]));
    end

    ////////////////////////////////////////////////////////////////////////
    // Derived controls, registered so analog-facing lines never glitch
    assign limit_code = bus.input_source_control[cicr_pkg::CODE_MSB:0];
    assign voltage_offset = bus.boost_temp_and_voltage_offset[cicr_pkg::OFFSET_MSB:0];
    assign reg_limit_ma = cicr_pkg::CURRENT_LIMIT_PIN_OFFSET_MA + 12'(limit_code) * cicr_pkg::CURRENT_LIMIT_PIN_STEP_MA;
    assign offset_mv = 16'(voltage_offset) * cicr_pkg::VOFF_STEP_MV;
    assign scaled_offset_mv = (vbus_noload_mv > cicr_pkg::VBUS_DOUBLE_MV)
        ? {offset_mv[14:0], 1'b0} : offset_mv;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            input_high_impedance_enable <= 1'b0;
            effective_input_current_limit_ma <= cicr_pkg::CURRENT_LIMIT_PIN_USB_MA;
            boost_hot_threshold_select <= 2'h0;
            boost_thermal_protect_enable <= 1'b1;
            boost_cold_threshold_select <= 1'b0;
            conversion_control <= cicr_pkg::RESET_CONVERSION;
        end
        else
        begin
            input_high_impedance_enable <= bus.input_source_control[cicr_pkg::HIZ_BIT];
            if (bus.input_source_control[cicr_pkg::LIMIT_PIN_ENABLE_BIT]
                && current_limit_pin_ma < reg_limit_ma)
                effective_input_current_limit_ma <= current_limit_pin_ma;
            else
                effective_input_current_limit_ma <= reg_limit_ma;
            boost_hot_threshold_select <=
                bus.boost_temp_and_voltage_offset[cicr_pkg::HOT_MSB:cicr_pkg::HOT_LSB];
            boost_cold_threshold_select <= bus.boost_temp_and_voltage_offset[cicr_pkg::COLD_BIT];
            boost_thermal_protect_enable <=
                bus.boost_temp_and_voltage_offset[cicr_pkg::HOT_MSB:cicr_pkg::HOT_LSB]
                != cicr_pkg::HOT_PROTECT_OFF;
            conversion_control <= bus.conversion_and_detection_control;
        end
    end

    // clamp, also when the offset exceeds the input
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            input_voltage_limit_threshold_mv <= cicr_pkg::VLIMIT_MIN_MV;
        else if (vbus_noload_mv < scaled_offset_mv + cicr_pkg::VLIMIT_MIN_MV)
            input_voltage_limit_threshold_mv <= cicr_pkg::VLIMIT_MIN_MV;
        else if (vbus_noload_mv - scaled_offset_mv > cicr_pkg::VLIMIT_MAX_MV)
            input_voltage_limit_threshold_mv <= cicr_pkg::VLIMIT_MAX_MV;
        else
            input_voltage_limit_threshold_mv <= vbus_noload_mv - scaled_offset_mv;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_address_reject: assert property (@(posedge clock) disable iff (!rst_b)
        scl_fall && !start_seen && !stop_seen && state == S_ADDR && bit_count == 4'h8
        && shift[7:1] != 7'h6b |=> state == S_IDLE ##1 sda_oe_b)
        else $error("foreign address not rejected");

    a_unmapped_read: assert property (@(posedge clock) disable iff (!rst_b)
        scl_fall && !start_seen && !stop_seen && state == S_ADDR_ACK && read_dir
        && reg_ptr > 8'h14 |=> tx == 8'hff)
        else $error("unmapped read not 0xFF");

    a_limit_minimum: assert property (@(posedge clock) disable iff (!rst_b)
        ##1 $stable(reg_limit_ma) && $stable(current_limit_pin_ma)
        |-> effective_input_current_limit_ma <= reg_limit_ma
            && (!$past(bus.input_source_control[6])
                || effective_input_current_limit_ma <= current_limit_pin_ma))
        else $error("effective limit not the minimum");

    a_code_weights: assert property (@(posedge clock) disable iff (!rst_b)
        ##1 $stable(reg_limit_ma) && !$past(bus.input_source_control[6])
        |-> effective_input_current_limit_ma == 12'h064 + 12'h032 * 12'($past(limit_code)))
        else $error("limit code arithmetic wrong");

    a_voltage_clamp: assert property (@(posedge clock) disable iff (!rst_b)
        input_voltage_limit_threshold_mv >= 16'h0f3c && input_voltage_limit_threshold_mv <= 16'h3bc4)
        else $error("voltage threshold outside clamp");

    a_hot_disable: assert property (@(posedge clock) disable iff (!rst_b)
        bus.boost_temp_and_voltage_offset[7:6] == 2'h3 |=> !boost_thermal_protect_enable)
        else $error("thermal protection not disabled");

    c_write_byte: cover property (@(posedge clock) disable iff (!rst_b)
        bus.write_strobe && bus.write_addr == 8'h01);
    c_read_byte: cover property (@(posedge clock) disable iff (!rst_b)
        state == S_RDATA_ACK && scl_fall && host_ack);
    c_address_nack: cover property (@(posedge clock) disable iff (!rst_b)
        state == S_ADDR && scl_fall && bit_count == 4'h8 && shift[7:1] != 7'h6b);

endmodule : cicr_top

// ---- verif/cicr_host.sv ----
// Serial bus host model driving a push-pull clock line and an open-drain data line
`timescale 1ns/1ps
module cicr_host (
    input wire logic clock,
    input wire logic sda,
    output logic scl = 1'b1,
    output logic sda_drive_b = 1'b1,
    output logic got = 1'b0,
    output logic [8:0] got_byte
);
    logic line;
    ////////////////////////////////////////
    // Moves land just after a clock edge, never on it
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : hold
    // One clock slot; a differs from b only for start or stop
    task automatic slot(input logic a, input logic b);
        scl = 1'b0;
        hold(5);
        sda_drive_b = a;
        hold(5);
        scl = 1'b1;
        hold(5);
        line = sda;
        hold(5);
        sda_drive_b = b;
        hold(5);
    endtask : slot
    // Eight bits first, then acknowledge; a 1 lets the line float high
    task automatic xfer(input logic [7:0] d, input logic a);
        for (int i = 8; i >= 0; i--)
        begin
            slot(i > 0 ? d[i - 1] : a, i > 0 ? d[i - 1] : a);
            got_byte[i] = line;
        end
        got = 1'b1;
        hold(1);
        got = 1'b0;
    endtask : xfer
endmodule : cicr_host

// ---- verif/charger_input_config_regs_tb_top.sv ----
// Self-checking bench for the input configuration bank
`timescale 1ns/1ps
module charger_input_config_regs_tb_top;
    logic clock = 1'b0, rst_b = 1'b0, reg_rst = 1'b0, wdog = 1'b0, det = 1'b0, sel = 1'b0;
    logic [11:0] pin_ma = 12'h0fff;
    logic [15:0] vbus_mv = 16'h1770;
    logic [31:0] seed = 32'h0000_a569;
    logic [23:0] sh;
    logic [8:0] exp_q[$];
    int fails = 0, n_tests = 0;
    wire scl, sda_b, got, sda_out, sda_oe_b, hiz, prot, cold;
    wire [8:0] got_byte;
    wire [11:0] lim_ma;
    wire [1:0] hot;
    wire [15:0] vlim_mv;
    wire [7:0] conv;
    wire [23:0] rst_vals = {cicr_pkg::RESET_INPUT_SOURCE, cicr_pkg::RESET_BOOST_TEMP,
        cicr_pkg::RESET_CONVERSION};
    // Open drain: low if either side pulls, pull-up otherwise
    wire sda = sda_b & (sda_oe_b | sda_out);
    cicr_host host (.clock(clock), .sda(sda), .scl(scl), .sda_drive_b(sda_b), .got(got),
        .got_byte(got_byte));
    cicr_top uut (.clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_b(sda_oe_b), .register_reset(reg_rst), .watchdog_expired(wdog),
        .detection_done(det), .source_select_pin(sel), .current_limit_pin_ma(pin_ma),
        .vbus_noload_mv(vbus_mv), .input_high_impedance_enable(hiz),
        .effective_input_current_limit_ma(lim_ma), .boost_hot_threshold_select(hot),
        .boost_thermal_protect_enable(prot), .boost_cold_threshold_select(cold),
        .input_voltage_limit_threshold_mv(vlim_mv), .conversion_control(conv));
    ////////////////////////////////////////
    // Clock, and a ceiling well above the expected run length
    initial
        forever #4 clock = ~clock;
    initial
    begin
        repeat (40000) @(posedge clock);
        fails++;
        finish_test();
    end
    // Each finished byte is matched against the oldest note
    always @(posedge got)
        compare(got_byte, exp_q.pop_front());
    task automatic compare(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : compare
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Offsets past the bank read zero, past the map all ones
    function automatic logic [7:0] expect_reg(input logic [7:0] a);
        return a < 3 ? sh[23 - 8 * a -: 8] : a <= 8'h14 ? 8'h00 : 8'hff;
    endfunction : expect_reg
    task automatic send(input logic [7:0] d, input logic a, input logic [8:0] e);
        exp_q.push_back(e);
        host.xfer(d, a);
    endtask : send
    task automatic open_t(input logic [6:0] ta, input logic rw, input logic nack);
        host.slot(1'b1, 1'b0);
        send({ta, rw}, 1'b1, {ta, rw, nack});
    endtask : open_t
    task automatic wr(input logic [23:0] d);
        open_t(cicr_pkg::TARGET_ADDR, 1'b0, 1'b0);
        send(8'h00, 1'b1, 9'h000);
        for (int i = 2; i >= 0; i--)
            send(d[8 * i +: 8], 1'b1, {d[8 * i +: 8], 1'b0});
        host.slot(1'b0, 1'b1);
        sh = d;
    endtask : wr
    task automatic rd(input logic [7:0] off, input int n);
        open_t(cicr_pkg::TARGET_ADDR, 1'b0, 1'b0);
        send(off, 1'b1, {off, 1'b0});
        open_t(cicr_pkg::TARGET_ADDR, 1'b1, 1'b0);
        for (int i = 0; i < n; i++)
            send(8'hff, i == n - 1, {expect_reg(8'(off + i)), i == n - 1});
        host.slot(1'b0, 1'b1);
    endtask : rd
    // Pulse a control input; bits in m fall back to reset values
    task automatic pulse(input logic [2:0] k, input logic [23:0] m);
        @(posedge clock);
        #1 {reg_rst, wdog, det} = k;
        @(posedge clock);
        #1 {reg_rst, wdog, det} = 3'b000;
        sh = sh & ~m | rst_vals & m;
    endtask : pulse
    task automatic check_outs();
        int lim, off, v;
        lim = 100 + 50 * sh[21:16];
        if (sh[22] && pin_ma < lim)
            lim = pin_ma;
        off = 100 * sh[12:8] * (vbus_mv > 6000 ? 2 : 1);
        v = vbus_mv - off;
        v = v < 3900 ? 3900 : v > 15300 ? 15300 : v;
        repeat (3) @(posedge clock);
        #1 compare({hiz, lim_ma, hot, prot, cold, vlim_mv, conv}, {sh[23], 12'(lim), sh[15:14],
            sh[15:14] != 2'b11, sh[13], 16'(v), sh[7:0]});
    endtask : check_outs
    ////////////////////////////////////////
    // Main sequence; the vbus table straddles the doubling point and both clamps
    initial
    begin
        logic [63:0] vt;
        vt = 64'h1770_1771_07d0_4e20;
        repeat (8) @(posedge clock);
        #1 rst_b = 1'b1;
        sh = rst_vals;
        rd(8'h00, 3);
        check_outs();
        for (int h = 0; h < 4; h++)
        begin
            pin_ma = 12'(rnd() % 3400);
            vbus_mv = vt[48 - 16 * h +: 16];
            wr({8'(rnd()), 2'(h), 14'(rnd())});
            rd(8'h00, 3);
            check_outs();
        end
        rd(8'h14, 2);
        open_t(cicr_pkg::TARGET_ADDR ^ 7'h01, 1'b0, 1'b1);
        host.slot(1'b0, 1'b1);
        pulse(3'b010, {cicr_pkg::WATCHDOG_MASK_INPUT_SOURCE, cicr_pkg::WATCHDOG_MASK_BOOST_TEMP,
            cicr_pkg::WATCHDOG_MASK_CONVERSION});
        rd(8'h00, 3);
        for (int s = 1; s >= 0; s--)
        begin
            sel = s[0];
            repeat (4) @(posedge clock);
            pulse(3'b001, 24'h00_0000);
            sh[21:16] = s ? 6'h08 : 6'h3f;
            rd(8'h00, 1);
        end
        pulse(3'b100, 24'hff_ffff);
        rd(8'h00, 3);
        check_outs();
        finish_test();
    end
endmodule : charger_input_config_regs_tb_top
